// [logic/pulse_counter.sv]
// Four-channel configurable pulse counter with preset outputs.
// Assumes inputs synchronous to mclk and a host that refreshes its
// control word each sweep and reports link health on link_ok.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`default_nettype none

//Contract
//- Link loss applies fail mode to outputs
//- Oscillator setting selects counter 1 source
//- Oscillator is 660 kHz over divider N
//- Filters reject 2.5 us or 12.5 ms
//- Kind A filters grouped by counter pairs; code filters preload inputs 3 and 4 singly
//- Kind A has four configured counters
//- Direction bit picks up or down
//- Continuous mode wraps to other limit
//- One-shot mode stops at limit
//- Strobe edge rising or falling selectable
//- Rate measured over millisecond interval
//- Upper bound defaults to 32767
//- Lower bound per counter independently
//- Output on at on threshold if enabled
//- Output off at off threshold
//- Preload input loads preload value
//- Kind B three input encodings
//- Kind B disable input with filter
//- Kind B filter per counter, shared preload
//- Kind B two preset pairs per counter
//- Kind B values held 32 bits
//- Sixteen control and status bits per sweep
//- Fifteen data words returned per sweep
module pulse_counter
   import pulse_counter_pkg::*;
#(
   parameter int FILT_LO_CYCLES = FILT_LO_CYC,
   parameter int MS_CYCLES      = MS_CYC
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   // Register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   // Field inputs
   input  wire logic [3:0]         count_in,
   input  wire logic [1:0]         aux_in,
   input  wire logic [3:0]         preload_in,
   input  wire logic [3:0]         strobe_in,
   input  wire logic [1:0]         disable_in,
   // Field outputs
   output logic      [3:0]         preset_out,
   // Host sweep exchange
   input  wire logic               link_ok,
   input  wire logic [15:0]        host_ctrl,
   output logic      [15:0]        host_status,
   output logic      [15*16-1:0]   host_words
);

   ////////////////////////////////////////////////////////////////////
   // Configuration registers

   logic              kind_b_q;
   fail_mode_t        fail_q;
   logic              osc_on_q;
   logic [15:0]       osc_div_q;
   logic [9:0]        filt_q;
   logic [15:0]       mode_q;
   chan_cfg_t         chan_q   [4];
   preset_cfg_t       preset_q [4];

   wire        in_chan  = reg_addr >= REG_CHAN_BASE && reg_addr < REG_ACC_BASE;
   wire [1:0]  wr_ch    = 2'(reg_addr[5:3] - REG_CHAN_BASE[5:3]);
   wire [2:0]  wr_fld   = reg_addr[2:0];
   wire        osc_ok   = reg_wdata[15:0] >= OSC_DIV_MIN;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         kind_b_q  <= 1'b0;
         fail_q    <= FAIL_NORMAL;
         osc_on_q  <= 1'b0;
         osc_div_q <= OSC_DIV_RST;
         filt_q    <= '0;
         mode_q    <= '0;
      end else if (reg_wr) begin
         if (reg_addr == REG_GLOBAL) begin
            kind_b_q <= reg_wdata[G_KIND];
            fail_q   <= fail_mode_t'(reg_wdata[G_FAIL +: 2]);
            osc_on_q <= reg_wdata[G_OSC];
         end else if (reg_addr == REG_OSC_DIV) begin
            // Divider below four is refused, old value kept
            if (osc_ok) osc_div_q <= reg_wdata[15:0];
         end else if (reg_addr == REG_FILTERS) begin
            filt_q <= reg_wdata[9:0];
         end else if (reg_addr == REG_CHAN_MODE) begin
            mode_q <= reg_wdata[15:0];
         end
      end
   end

   // Per-channel limits, thresholds, preload and interval
   generate
      for (genvar c = 0; c < 4; c++) begin : g_cfg
         wire sel = reg_wr && in_chan && wr_ch == 2'(c);
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               chan_q[c].rate_interval  <= RATE_RST;
               chan_q[c].upper_bound    <= UPPER_RST;
               chan_q[c].lower_bound    <= ZERO_RST;
               chan_q[c].preload        <= ZERO_RST;
               preset_q[c].on_threshold <= UPPER_RST;
               preset_q[c].off_threshold <= ZERO_RST;
            end else if (sel) begin
               if (wr_fld == CH_RATE)
                  chan_q[c].rate_interval <= reg_wdata[15:0];
               else if (wr_fld == CH_UPPER)
                  chan_q[c].upper_bound <= reg_wdata;
               else if (wr_fld == CH_LOWER)
                  chan_q[c].lower_bound <= reg_wdata;
               else if (wr_fld == CH_ON)
                  preset_q[c].on_threshold <= reg_wdata;
               else if (wr_fld == CH_OFF)
                  preset_q[c].off_threshold <= reg_wdata;
               else if (wr_fld == CH_PRELOAD)
                  chan_q[c].preload <= reg_wdata;
            end
         end
      end
   endgenerate

   // Counter that owns strobe or preset unit j
   function automatic logic [1:0] owner(input logic kb,
                                        input logic [1:0] j);
      owner = kb ? {1'b0, j[1]} : j;
   endfunction : owner

   ////////////////////////////////////////////////////////////////////
   // Input filters: a level is accepted after it stays stable

   wire [N_IN-1:0] raw_in = {disable_in, strobe_in, preload_in,
                             aux_in, count_in};
   logic [N_IN-1:0] filt_low;

   always_comb begin
      filt_low = '0;
      if (kind_b_q) begin
         filt_low[IN_CNT]   = filt_q[F_CNTB1];
         filt_low[IN_CNT+1] = filt_q[F_CNTB2];
         filt_low[IN_AUX]   = filt_q[F_CNTB1];
         filt_low[IN_AUX+1] = filt_q[F_CNTB2];
         filt_low[IN_PLD]   = filt_q[F_PLDB];
         filt_low[IN_PLD+1] = filt_q[F_PLDB];
         filt_low[IN_DIS]   = filt_q[F_DIS1];
         filt_low[IN_DIS+1] = filt_q[F_DIS2];
      end else begin
         filt_low[IN_CNT]   = filt_q[F_CNT12];
         filt_low[IN_CNT+1] = filt_q[F_CNT12];
         filt_low[IN_CNT+2] = filt_q[F_CNT34];
         filt_low[IN_CNT+3] = filt_q[F_CNT34];
         filt_low[IN_PLD]   = filt_q[F_PLD12];
         filt_low[IN_PLD+1] = filt_q[F_PLD12];
         filt_low[IN_PLD+2] = filt_q[F_PLD3];
         filt_low[IN_PLD+3] = filt_q[F_PLD4];
      end
   end

   logic [N_IN-1:0] flt_q;
   logic [N_IN-1:0] flt_prev_q;

   generate
      for (genvar i = 0; i < N_IN; i++) begin : g_filt
         logic [FILT_W-1:0] run_q;
         wire  [FILT_W-1:0] limit = filt_low[i] ?
                                    FILT_W'(FILT_LO_CYCLES - 1) :
                                    FILT_W'(FILT_HI_CYC - 1);
         wire               diff  = raw_in[i] != flt_q[i];
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               run_q    <= '0;
               flt_q[i] <= 1'b0;
            end else if (!diff) begin
               run_q <= '0;
            end else if (run_q >= limit) begin
               run_q    <= '0;
               flt_q[i] <= raw_in[i];
            end else begin
               run_q <= run_q + 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) flt_prev_q <= '0;
      else         flt_prev_q <= flt_q;
   end

   wire [N_IN-1:0] rise = flt_q & ~flt_prev_q;
   wire [N_IN-1:0] fall = ~flt_q & flt_prev_q;

   ////////////////////////////////////////////////////////////////////
   // Reference oscillator and millisecond tick

   logic [31:0] osc_ph_q;
   logic        osc_tick_q;
   logic [31:0] ms_cnt_q;
   wire  [31:0] osc_wrap = 32'(osc_div_q) * OSC_SCALE;
   wire  [31:0] osc_sum  = osc_ph_q + OSC_STEP;
   wire         ms_tick  = ms_cnt_q == 32'(MS_CYCLES - 1);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_ph_q   <= '0;
         osc_tick_q <= 1'b0;
         ms_cnt_q   <= '0;
      end else begin
         osc_tick_q <= osc_sum >= osc_wrap;
         osc_ph_q   <= (osc_sum >= osc_wrap) ? osc_sum - osc_wrap
                                             : osc_sum;
         ms_cnt_q   <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counters

   logic signed [31:0] acc_q    [4];
   logic signed [31:0] stb_q    [4];
   logic signed [31:0] rate_q   [4];
   logic        [3:0]  at_lim;

   generate
      for (genvar c = 0; c < 4; c++) begin : g_cnt
         logic signed [31:0] net_q;
         logic        [15:0] ival_q;
         logic up_ev;
         logic dn_ev;
         wire  use_osc = c == 0 && osc_on_q;
         wire  a_rise  = use_osc ? osc_tick_q : rise[IN_CNT+c];
         wire  active  = !kind_b_q || c < 2;
         wire  dis     = kind_b_q && c < 2 &&
                         flt_q[IN_DIS + (c % 2)];
         wire  b_lvl   = flt_q[IN_AUX + (c % 2)];
         wire  b_rise  = rise[IN_AUX + (c % 2)];
         wire  a_chg   = rise[IN_CNT+c] | fall[IN_CNT+c];
         wire  b_chg   = b_rise | fall[IN_AUX + (c % 2)];
         wire  ab      = flt_q[IN_CNT+c] ^ b_lvl;
         wire  [1:0] enc = c == 0 ? mode_q[M_ENC1 +: 2]
                                  : mode_q[M_ENC2 +: 2];

         always_comb begin
            up_ev = 1'b0;
            dn_ev = 1'b0;
            if (!kind_b_q) begin
               up_ev = a_rise && !mode_q[M_DOWN+c];
               dn_ev = a_rise &&  mode_q[M_DOWN+c];
            end else if (enc == ENC_UP_DOWN && !use_osc) begin
               up_ev = a_rise;
               dn_ev = b_rise;
            end else if (enc == ENC_QUADRATURE && !use_osc) begin
               up_ev = a_chg ^ b_chg ? (a_chg ? ab : !ab) : 1'b0;
               dn_ev = a_chg ^ b_chg ? (a_chg ? !ab : ab) : 1'b0;
            end else begin
               // Pulse plus direction; also the oscillator's format
               up_ev = a_rise && !b_lvl;
               dn_ev = a_rise &&  b_lvl;
            end
         end

         wire step_up = active && !dis && up_ev && !dn_ev;
         wire step_dn = active && !dis && dn_ev && !up_ev;
         wire once    = mode_q[M_ONCE+c];
         wire hi_hit  = acc_q[c] >= chan_q[c].upper_bound;
         wire lo_hit  = acc_q[c] <= chan_q[c].lower_bound;
         wire ival_end = ms_tick &&
                         ival_q + 16'h0001 >= chan_q[c].rate_interval;
         wire signed [31:0] net_d = step_up ? net_q + 32'sd1 :
                                    step_dn ? net_q - 32'sd1 : net_q;
         assign at_lim[c] = once && (hi_hit || lo_hit);

         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               acc_q[c] <= '0;
            end else if (rise[IN_PLD+c]) begin
               acc_q[c] <= chan_q[c].preload;
            end else if (step_up) begin
               if (!hi_hit)   acc_q[c] <= acc_q[c] + 32'sd1;
               else if (!once)
                  acc_q[c] <= chan_q[c].lower_bound;
               // One-shot holds at the upper bound
            end else if (step_dn) begin
               if (!lo_hit)   acc_q[c] <= acc_q[c] - 32'sd1;
               else if (!once)
                  acc_q[c] <= chan_q[c].upper_bound;
            end
         end

         // Net count per interval; a late interval change takes
         // effect at the next millisecond tick
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               net_q     <= '0;
               ival_q    <= '0;
               rate_q[c] <= '0;
            end else if (ival_end) begin
               rate_q[c] <= net_d;
               net_q     <= '0;
               ival_q    <= '0;
            end else begin
               net_q  <= net_d;
               ival_q <= ms_tick ? ival_q + 16'h0001 : ival_q;
            end
         end

         // Strobe c captures the accumulator of its owner
         wire [1:0] own = owner(kind_b_q, 2'(c));
         wire edge_hit  = mode_q[M_NEG+c] ? fall[IN_STB+c]
                                          : rise[IN_STB+c];
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst)       stb_q[c] <= '0;
            else if (edge_hit) stb_q[c] <= acc_q[own];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Preset outputs and fail mode

   logic [3:0] unit_q;

   generate
      for (genvar j = 0; j < 4; j++) begin : g_pst
         wire [1:0] own = owner(kind_b_q, 2'(j));
         wire hit_off = acc_q[own] == preset_q[j].off_threshold;
         wire hit_on  = acc_q[own] == preset_q[j].on_threshold;
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst)      unit_q[j] <= 1'b0;
            else if (hit_off) unit_q[j] <= 1'b0;
            else if (hit_on)  unit_q[j] <= 1'b1;
         end
      end
   endgenerate

   // Output-enable flags come from the host control word
   wire [3:0] drive = unit_q & host_ctrl[3:0];
   logic [3:0] out_d;

   always_comb begin
      out_d = drive;
      if (!link_ok) begin
         case (fail_q)
            FAIL_FORCE_OFF: out_d = 4'h0;
            FAIL_HOLD:      out_d = preset_out;
            default:        out_d = drive;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) preset_out <= 4'h0;
      else         preset_out <= out_d;
   end

   ////////////////////////////////////////////////////////////////////
   // Host sweep data and register read-back

   wire [15:0] status_d = {6'h00, kind_b_q, link_ok, at_lim, preset_out};
   logic [15*16-1:0] words_d;

   always_comb begin
      words_d = '0;
      for (int k = 0; k < 4; k++) begin
         words_d[16*k      +: 16] = acc_q[k][15:0];
         words_d[16*(k+4)  +: 16] = stb_q[k][15:0];
         words_d[16*(k+8)  +: 16] = rate_q[k][15:0];
      end
      words_d[16*12 +: 16] = acc_q[0][31:16];
      words_d[16*13 +: 16] = acc_q[1][31:16];
      words_d[16*14 +: 16] = status_d;
   end

   logic [31:0] rd_mux;
   wire  [1:0]  rd_k = reg_addr[1:0];

   always_comb begin
      rd_mux = '0;
      if (reg_addr == REG_GLOBAL)
         rd_mux = {28'h0, osc_on_q, fail_q, kind_b_q};
      else if (reg_addr == REG_OSC_DIV)
         rd_mux = {16'h0, osc_div_q};
      else if (reg_addr == REG_FILTERS)
         rd_mux = {22'h0, filt_q};
      else if (reg_addr == REG_CHAN_MODE)
         rd_mux = {16'h0, mode_q};
      else if (reg_addr == REG_STATUS)
         rd_mux = {16'h0, status_d};
      else if (in_chan && wr_fld == CH_RATE)
         rd_mux = {16'h0, chan_q[wr_ch].rate_interval};
      else if (in_chan && wr_fld == CH_UPPER)
         rd_mux = chan_q[wr_ch].upper_bound;
      else if (in_chan && wr_fld == CH_LOWER)
         rd_mux = chan_q[wr_ch].lower_bound;
      else if (in_chan && wr_fld == CH_ON)
         rd_mux = preset_q[wr_ch].on_threshold;
      else if (in_chan && wr_fld == CH_OFF)
         rd_mux = preset_q[wr_ch].off_threshold;
      else if (in_chan && wr_fld == CH_PRELOAD)
         rd_mux = chan_q[wr_ch].preload;
      else if (reg_addr[7:2] == REG_ACC_BASE[7:2])
         rd_mux = acc_q[rd_k];
      else if (reg_addr[7:2] == REG_STB_BASE[7:2])
         rd_mux = stb_q[rd_k];
      else if (reg_addr[7:2] == REG_RATE_BASE[7:2])
         rd_mux = rate_q[rd_k];
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata   <= '0;
         host_status <= '0;
         host_words  <= '0;
      end else begin
         reg_rdata   <= reg_rd ? rd_mux : 32'h0;
         host_status <= status_d;
         host_words  <= words_d;
      end
   end

endmodule : pulse_counter
`default_nettype wire

// [logic/pulse_counter_pkg.sv]
// Shared constants, register map and types for the pulse counter.
// Assumes a single 200 MHz clock and a plain register port.
`default_nettype none
package pulse_counter_pkg;

   localparam int CLK_MHZ = 200;

   // Filter and time-base timing in their own units, then in cycles
   localparam int FILT_HI_NS    = 2500;
   localparam int FILT_HI_CYC   = (FILT_HI_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT_LO_US    = 12500;
   localparam int FILT_LO_CYC   = FILT_LO_US * CLK_MHZ;
   localparam int MS_US         = 1000;
   localparam int MS_CYC        = MS_US * CLK_MHZ;
   localparam int FILT_W        = 22;

   // Reference oscillator: f = 660 kHz / N, phase step per clock
   localparam logic [31:0] OSC_STEP     = 32'd33;
   localparam logic [31:0] OSC_SCALE    = 32'd10000;
   localparam logic [15:0] OSC_DIV_MIN  = 16'h0004;
   localparam logic [15:0] OSC_DIV_RST  = 16'h0294;

   // Reset values
   localparam logic [15:0] RATE_RST     = 16'h03e8;
   localparam logic [31:0] UPPER_RST    = 32'h0000_7fff;
   localparam logic [31:0] ZERO_RST     = 32'h0000_0000;

   // Register offsets (word index)
   localparam logic [7:0] REG_GLOBAL    = 8'h00;
   localparam logic [7:0] REG_OSC_DIV   = 8'h01;
   localparam logic [7:0] REG_FILTERS   = 8'h02;
   localparam logic [7:0] REG_CHAN_MODE = 8'h03;
   localparam logic [7:0] REG_STATUS    = 8'h04;
   localparam logic [7:0] REG_CHAN_BASE = 8'h10;
   localparam logic [7:0] REG_ACC_BASE  = 8'h30;
   localparam logic [7:0] REG_STB_BASE  = 8'h34;
   localparam logic [7:0] REG_RATE_BASE = 8'h38;
   // Offsets inside one channel block of eight words
   localparam logic [2:0] CH_RATE       = 3'h0;
   localparam logic [2:0] CH_UPPER      = 3'h1;
   localparam logic [2:0] CH_LOWER      = 3'h2;
   localparam logic [2:0] CH_ON         = 3'h3;
   localparam logic [2:0] CH_OFF        = 3'h4;
   localparam logic [2:0] CH_PRELOAD    = 3'h5;

   // Global register fields
   localparam int G_KIND  = 0;
   localparam int G_FAIL  = 1;
   localparam int G_OSC   = 3;
   // Filter register fields (1 selects the low-frequency filter)
   localparam int F_CNT12 = 0;
   localparam int F_CNT34 = 1;
   localparam int F_PLD12 = 2;
   localparam int F_PLD3  = 3;
   localparam int F_PLD4  = 4;
   localparam int F_CNTB1 = 5;
   localparam int F_CNTB2 = 6;
   localparam int F_PLDB  = 7;
   localparam int F_DIS1  = 8;
   localparam int F_DIS2  = 9;
   // Channel mode register fields
   localparam int M_DOWN  = 0;
   localparam int M_ONCE  = 4;
   localparam int M_NEG   = 8;
   localparam int M_ENC1  = 12;
   localparam int M_ENC2  = 14;

   // Filtered input vector layout
   localparam int IN_CNT  = 0;
   localparam int IN_AUX  = 4;
   localparam int IN_PLD  = 6;
   localparam int IN_STB  = 10;
   localparam int IN_DIS  = 14;
   localparam int N_IN    = 16;

   typedef enum logic [1:0] {
      FAIL_NORMAL    = 2'b00,
      FAIL_FORCE_OFF = 2'b01,
      FAIL_HOLD      = 2'b10
   } fail_mode_t;

   typedef enum logic [1:0] {
      ENC_PULSE_DIR  = 2'b00,
      ENC_UP_DOWN    = 2'b01,
      ENC_QUADRATURE = 2'b10
   } encoding_t;

   typedef struct packed {
      logic [15:0]        rate_interval;
      logic signed [31:0] upper_bound;
      logic signed [31:0] lower_bound;
      logic signed [31:0] preload;
   } chan_cfg_t;

   typedef struct packed {
      logic signed [31:0] on_threshold;
      logic signed [31:0] off_threshold;
   } preset_cfg_t;

endpackage : pulse_counter_pkg
`default_nettype wire

// [tb/host_cpu_model.sv]
// Controller side of the sweep exchange: control word and link health.
// Assumes the bench steers enables and link loss from outside.
`default_nettype none
module host_cpu_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // Bench steering
   input  wire logic [3:0]  out_enable,
   input  wire logic        link_drop,
   // Sweep exchange
   output logic             link_ok,
   output logic [15:0]      host_ctrl
);
   timeunit 1ns;
   timeprecision 1ps;
   // A fresh control word every sweep, one sweep per clock here
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         link_ok   <= 1'b0;
         host_ctrl <= 16'h0000;
      end else begin
         link_ok   <= !link_drop;
         host_ctrl <= {12'h000, out_enable};
      end
   end
endmodule : host_cpu_model
`default_nettype wire

// [tb/pulse_counter_asserts.sv]
// Port-level checks for the pulse counter.
// Assumes it is bound into pulse_counter and sees only its ports.
`default_nettype none
module pulse_counter_asserts
   import pulse_counter_pkg::*;
#(
   parameter int FILT_LO_CYCLES = 20,
   parameter int MS_CYCLES      = 10
) (
   input wire logic          mclk,
   input wire logic          sys_rst,
   input wire logic [7:0]    reg_addr,
   input wire logic          reg_rd,
   input wire logic [31:0]   reg_rdata,
   input wire logic          link_ok,
   input wire logic [15:0]   host_ctrl,
   input wire logic [3:0]    preset_out,
   input wire logic [15:0]   host_status,
   input wire logic [239:0]  host_words
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   AST_RD_UNMAPPED: assert property
      ($past(reg_rd) && $past(reg_addr) == 8'hff |-> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RESET_QUIET: assert property
      ($fell(sys_rst) |-> preset_out == 4'h0 && reg_rdata == 32'h0)
      else $error("outputs busy after reset");
   AST_LINK_MIRROR: assert property (!$past(sys_rst) |->
      host_status[8] == $past(link_ok)) else $error("link bit wrong");
   AST_STATUS_PAD: assert property (host_status[15:10] == 6'h0)
      else $error("status pad bits set");
   AST_STATUS_OUT: assert property (!$past(sys_rst) |->
      host_status[3:0] == $past(preset_out)) else $error("status outs");
   AST_ON_NEEDS_EN: assert property ($rose(preset_out[1]) |->
      host_ctrl[1] || $past(host_ctrl[1]) || $past(host_ctrl[1], 2))
      else $error("output on while disabled");
   AST_ACC_WORD: assert property ($past(reg_rd) &&
      $past(reg_addr) == REG_ACC_BASE |-> reg_rdata[15:0] == host_words[15:0])
      else $error("sweep word differs from register");
   COV_OUT_ON: cover property ($rose(preset_out[1]));
   COV_LINK_LOSS: cover property ($fell(link_ok));
   COV_ACC_READ: cover property (reg_rd && reg_addr == REG_ACC_BASE);
endmodule : pulse_counter_asserts
bind pulse_counter pulse_counter_asserts #(
   .FILT_LO_CYCLES(FILT_LO_CYCLES), .MS_CYCLES(MS_CYCLES)) u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .link_ok(link_ok), .host_ctrl(host_ctrl),
   .preset_out(preset_out), .host_status(host_status),
   .host_words(host_words));
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the pulse counter with a controller model.
// Assumes short filter and millisecond parameters for run time.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pulse_counter_pkg::*;
   logic          mclk, sys_rst, reg_wr, reg_rd, link_ok, drop;
   logic [7:0]    reg_addr;
   logic [31:0]   reg_wdata, reg_rdata;
   logic [11:0]   fin;
   logic [3:0]    preset_out, en;
   logic [15:0]   host_ctrl, host_status;
   logic [239:0]  host_words;
   int            mismatches, tests_run, cycles;
   pulse_counter #(.FILT_LO_CYCLES(20), .MS_CYCLES(10)) uut (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .count_in(fin[3:0]), .aux_in(2'h0),
      .preload_in(fin[7:4]), .strobe_in(fin[11:8]), .disable_in(2'h0),
      .preset_out(preset_out), .link_ok(link_ok), .host_ctrl(host_ctrl),
      .host_status(host_status), .host_words(host_words));
   host_cpu_model host (.mclk(mclk), .sys_rst(sys_rst), .out_enable(en),
      .link_drop(drop), .link_ok(link_ok), .host_ctrl(host_ctrl));
   ////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task hold(input int n);
      repeat (n) @(posedge mclk);
   endtask : hold
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   // Held well past the 500-cycle filter so every level is accepted
   task lvl(input int i, input logic v);
      @(posedge mclk);
      fin[i] <= v;
      hold(520);
   endtask : lvl
   task pulse(input int i);
      lvl(i, 1'b1);
      lvl(i, 1'b0);
   endtask : pulse
   ////////////////////////////////////////////////////////////////////
   task t_defaults;
      rd(REG_OSC_DIV, 32'h294);
      rd(8'h10, 32'h3e8);
      rd(8'h11, 32'h7fff);
      rd(8'h12, 32'h0);
      wr(REG_OSC_DIV, 32'h3);
      rd(REG_OSC_DIV, 32'h294);
      rd(8'hff, 32'h0);
   endtask : t_defaults
   task t_count;
      // Config download: ch2 down, ch3 one-shot, ch0 falling strobe
      wr(REG_CHAN_MODE, 32'h184);
      wr(8'h29, 32'h1);
      pulse(1);
      rd(8'h31, 32'h1);
      pulse(2);
      rd(8'h32, 32'h7fff);
      pulse(3);
      pulse(3);
      rd(8'h33, 32'h1);
   endtask : t_count
   task t_load_strobe;
      wr(8'h15, 32'h5);
      pulse(4);
      rd(REG_ACC_BASE, 32'h5);
      lvl(8, 1'b1);
      rd(REG_STB_BASE, 32'h0);
      lvl(8, 1'b0);
      rd(REG_STB_BASE, 32'h5);
   endtask : t_load_strobe
   task t_presets;
      en <= 4'h2;
      wr(8'h1b, 32'h2);
      pulse(1);
      chk({31'h0, preset_out[1]}, 32'h1);
      wr(REG_GLOBAL, 32'h2);
      drop <= 1'b1;
      hold(5);
      chk({31'h0, preset_out[1]}, 32'h0);
      wr(REG_GLOBAL, 32'h4);
      drop <= 1'b0;
      hold(5);
      drop <= 1'b1;
      hold(5);
      chk({31'h0, preset_out[1]}, 32'h1);
      drop <= 1'b0;
      wr(8'h1c, 32'h2);
      hold(5);
      chk({31'h0, preset_out[1]}, 32'h0);
   endtask : t_presets
   task t_osc;
      wr(REG_OSC_DIV, 32'h4);
      wr(REG_CHAN_MODE, 32'h0184);
      wr(REG_GLOBAL, 32'h9);
      hold(3000);
      chk({31'h0, host_words[15:0] > 16'h5}, 32'h1);
      chk({31'h0, host_status[9]}, 32'h1);
   endtask : t_osc
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, drop, fin, en} = {4'h8, 12'h0, 4'h0};
      {reg_addr, reg_wdata, mismatches, tests_run, cycles} = '0;
      hold(3);
      sys_rst <= 1'b0;
      t_defaults();
      t_count();
      t_load_strobe();
      t_presets();
      t_osc();
      end_sim();
   end
endmodule : tb
`default_nettype wire
